// file: host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	input wire logic [7:0] rdata,
	input wire logic rdata_valid,
	output logic wr_en = 1'b0,
	output logic rd_en = 1'b0,
	output logic [7:0] addr = 8'h00,
	output logic [7:0] wdata = 8'h00,
	output logic high_speed_write = 1'b0
);
	// ****************************************
	// single-byte register transfers
	// ****************************************
	// hs follows a random seed bit on every write; only the 97h register refuses it
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic hs);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		high_speed_write <= hs;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		wdata <= ~d;
		high_speed_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
		v = rdata_valid;
	endtask
endmodule

// file: panel_cfg_pkg.sv
package panel_cfg_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] scan_direction_control_addr = 8'h90;
	localparam logic [7:0] self_test_control_addr = 8'h91;
	localparam logic [7:0] black_insertion_control_addr = 8'h92;
	localparam logic [7:0] panel_layout_control_addr = 8'h93;
	localparam logic [7:0] termination_select_addr = 8'h97;
	localparam logic [7:0] start_pulse_oe1_width_addr = 8'had;
	localparam logic [7:0] oe2_width_addr = 8'hae;

	// ****************************************
	// reset values and fixed bits
	// ****************************************
	localparam logic [7:0] scan_direction_control_rst = 8'hff;
	localparam logic [7:0] scan_direction_fixed = 8'hfc;
	localparam logic [7:0] scan_direction_wmask = 8'h03;
	localparam logic [7:0] self_test_control_rst = 8'h07;
	localparam logic [7:0] self_test_fixed = 8'h04;
	localparam logic [7:0] self_test_wmask = 8'h03;
	localparam logic [7:0] black_insertion_control_rst = 8'hcf;
	localparam logic [7:0] black_insertion_fixed = 8'hce;
	localparam logic [7:0] black_insertion_wmask = 8'h01;
	localparam logic [7:0] panel_layout_control_rst = 8'hff;
	localparam logic [7:0] panel_layout_fixed = 8'h0c;
	localparam logic [7:0] panel_layout_wmask = 8'hf3;
	localparam logic [7:0] termination_select_rst = 8'h00;
	localparam logic [7:0] start_pulse_oe1_width_rst = 8'h90;
	localparam logic [7:0] oe2_width_rst = 8'h54;
	localparam logic [7:0] oe2_width_wmask = 8'h7f;

	// ****************************************
	// field positions
	// ****************************************
	localparam int horizontal_direction_bit = 0;
	localparam int vertical_direction_bit = 1;
	localparam int self_test_enable_n_bit = 0;
	localparam int self_test_clock_select_bit = 1;
	localparam int black_insertion_bit = 0;
	localparam int port_count_select_bit = 7;
	localparam int driving_method_bit = 6;
	localparam int zz_layout_type_bit = 5;
	localparam int panel_polarity_bit = 4;
	localparam int start_pulse_length_n_bit = 7;

	// ****************************************
	// encodings and counts
	// ****************************************
	localparam logic [1:0] res_1080x1920 = 2'h1;
	localparam logic [6:0] oe_width_min = 7'h02;
	localparam logic [10:0] source_count = 11'h4b0;
	localparam logic [10:0] disabled_first = 11'h32b;
	localparam logic [10:0] disabled_last = 11'h3de;
	localparam logic [3:0] ui_per_oe_step = 4'hc;

	typedef enum logic [1:0] {
		term_100_ohm,
		term_250_ohm,
		term_150_ohm,
		term_75_ohm
	} term_code_type;

	typedef struct packed {
		logic horizontal_direction;
		logic vertical_direction;
		logic self_test_clock_select;
		logic self_test_enable_n;
		logic black_insertion;
		logic port_count_select;
		logic driving_method;
		logic zz_layout_type;
		logic panel_polarity;
		logic [1:0] resolution_select;
		logic [7:0] termination;
		logic start_pulse_length_n;
		logic [6:0] first_oe_width;
		logic [6:0] second_oe_width;
	} settings_type;

endpackage

// file: panel_timing_config_regs.sv
`timescale 1ns/1ps
module panel_timing_config_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic global_reset_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic high_speed_write,
	input wire logic vsync_valid,
	input wire logic port_count_pin,
	input wire logic vstart_req,
	input wire logic [1:0] driver_location,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output panel_cfg_pkg::settings_type active,
	output logic two_port_mode,
	output logic first_start_output,
	output logic second_start_output,
	output logic scan_direction_output,
	output logic channels_disabled,
	output panel_cfg_pkg::term_code_type term_select,
	output logic [10:0] first_oe_ui,
	output logic first_oe_supported
);

	// ****************************************
	// pending register images
	// ****************************************
	logic [7:0] scan_direction_control;
	logic [7:0] self_test_control;
	logic [7:0] black_insertion_control;
	logic [7:0] panel_layout_control;
	logic [7:0] termination_select;
	logic [7:0] start_pulse_oe1_width;
	logic [7:0] oe2_width;
	panel_cfg_pkg::settings_type next_active;
	// applied set after rst or global reset, mirrors the register reset images
	localparam panel_cfg_pkg::settings_type active_rst = '{
		horizontal_direction: 1'b1, vertical_direction: 1'b1,
		self_test_clock_select: 1'b1, self_test_enable_n: 1'b1,
		black_insertion: 1'b1, port_count_select: 1'b1,
		driving_method: 1'b1, zz_layout_type: 1'b1,
		panel_polarity: 1'b1, resolution_select: 2'h3,
		termination: 8'h00, start_pulse_length_n: 1'b1,
		first_oe_width: 7'h10, second_oe_width: 7'h54};

	// global reset acts at once, not at vsync
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scan_direction_control <= panel_cfg_pkg::scan_direction_control_rst;
			self_test_control <= panel_cfg_pkg::self_test_control_rst;
			black_insertion_control <=
				panel_cfg_pkg::black_insertion_control_rst;
			panel_layout_control <= panel_cfg_pkg::panel_layout_control_rst;
			termination_select <= panel_cfg_pkg::termination_select_rst;
			start_pulse_oe1_width <= panel_cfg_pkg::start_pulse_oe1_width_rst;
			oe2_width <= panel_cfg_pkg::oe2_width_rst;
		end else if (!global_reset_n) begin
			scan_direction_control <= panel_cfg_pkg::scan_direction_control_rst;
			self_test_control <= panel_cfg_pkg::self_test_control_rst;
			black_insertion_control <=
				panel_cfg_pkg::black_insertion_control_rst;
			panel_layout_control <= panel_cfg_pkg::panel_layout_control_rst;
			termination_select <= panel_cfg_pkg::termination_select_rst;
			start_pulse_oe1_width <= panel_cfg_pkg::start_pulse_oe1_width_rst;
			oe2_width <= panel_cfg_pkg::oe2_width_rst;
		end else if (wr_en) begin
			unique case (addr)
			panel_cfg_pkg::scan_direction_control_addr: begin
				scan_direction_control <=
					(wdata & panel_cfg_pkg::scan_direction_wmask)
					| panel_cfg_pkg::scan_direction_fixed;
			end
			panel_cfg_pkg::self_test_control_addr: begin
				self_test_control <= (wdata & panel_cfg_pkg::self_test_wmask)
					| panel_cfg_pkg::self_test_fixed;
			end
			panel_cfg_pkg::black_insertion_control_addr: begin
				black_insertion_control <=
					(wdata & panel_cfg_pkg::black_insertion_wmask)
					| panel_cfg_pkg::black_insertion_fixed;
			end
			panel_cfg_pkg::panel_layout_control_addr: begin
				panel_layout_control <=
					(wdata & panel_cfg_pkg::panel_layout_wmask)
					| panel_cfg_pkg::panel_layout_fixed;
			end
			panel_cfg_pkg::termination_select_addr: begin
				// high-speed writes are dropped as a safeguard
				if (!high_speed_write) begin
					termination_select <= wdata;
				end
			end
			panel_cfg_pkg::start_pulse_oe1_width_addr: begin
				start_pulse_oe1_width <= wdata;
			end
			panel_cfg_pkg::oe2_width_addr: begin
				oe2_width <= wdata & panel_cfg_pkg::oe2_width_wmask;
			end
			default: begin
			end
			endcase
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= rd_en;
			if (rd_en) begin
				unique case (addr)
				panel_cfg_pkg::scan_direction_control_addr:
					rdata <= scan_direction_control;
				panel_cfg_pkg::self_test_control_addr:
					rdata <= self_test_control;
				panel_cfg_pkg::black_insertion_control_addr:
					rdata <= black_insertion_control;
				panel_cfg_pkg::panel_layout_control_addr:
					rdata <= panel_layout_control;
				panel_cfg_pkg::termination_select_addr:
					rdata <= termination_select;
				panel_cfg_pkg::start_pulse_oe1_width_addr:
					rdata <= start_pulse_oe1_width;
				panel_cfg_pkg::oe2_width_addr: rdata <= oe2_width;
				// unmapped offsets read as zero
				default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// shadow transfer at vsync
	// ****************************************
	always_comb begin
		next_active = active;
		next_active.horizontal_direction = scan_direction_control
			[panel_cfg_pkg::horizontal_direction_bit];
		next_active.vertical_direction = scan_direction_control
			[panel_cfg_pkg::vertical_direction_bit];
		next_active.self_test_clock_select =
			self_test_control[panel_cfg_pkg::self_test_clock_select_bit];
		next_active.self_test_enable_n =
			self_test_control[panel_cfg_pkg::self_test_enable_n_bit];
		next_active.black_insertion =
			black_insertion_control[panel_cfg_pkg::black_insertion_bit];
		next_active.port_count_select =
			panel_layout_control[panel_cfg_pkg::port_count_select_bit];
		next_active.driving_method =
			panel_layout_control[panel_cfg_pkg::driving_method_bit];
		next_active.zz_layout_type =
			panel_layout_control[panel_cfg_pkg::zz_layout_type_bit];
		next_active.panel_polarity =
			panel_layout_control[panel_cfg_pkg::panel_polarity_bit];
		next_active.resolution_select = panel_layout_control[1:0];
		next_active.termination = termination_select;
		next_active.start_pulse_length_n = start_pulse_oe1_width
			[panel_cfg_pkg::start_pulse_length_n_bit];
		next_active.first_oe_width = start_pulse_oe1_width[6:0];
		next_active.second_oe_width = oe2_width[6:0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active <= active_rst;
		end else if (!global_reset_n) begin
			// the pending images are cleared on this same edge, so skip them
			active <= active_rst;
		end else if (vsync_valid) begin
			active <= next_active;
		end
	end

	// ****************************************
	// derived controls
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			two_port_mode <= 1'b0;
			first_start_output <= 1'b0;
			second_start_output <= 1'b0;
			scan_direction_output <= 1'b0;
			channels_disabled <= 1'b0;
			term_select <= panel_cfg_pkg::term_100_ohm;
			first_oe_ui <= 11'h0c0;
			first_oe_supported <= 1'b1;
		end else begin
			// pin and bit both default high, so one-port out of reset
			two_port_mode <= port_count_pin ^ active.port_count_select;
			first_start_output <= vstart_req && !active.vertical_direction;
			second_start_output <= vstart_req && active.vertical_direction;
			scan_direction_output <= !active.vertical_direction;
			channels_disabled <=
				active.resolution_select == panel_cfg_pkg::res_1080x1920;
			term_select <= panel_cfg_pkg::term_code_type'(
				active.termination[2*driver_location +: 2]);
			// code 7fh gives 1524 ui, which needs eleven bits
			first_oe_ui <= 11'(active.first_oe_width)
				* 11'(panel_cfg_pkg::ui_per_oe_step);
			first_oe_supported <=
				active.first_oe_width >= panel_cfg_pkg::oe_width_min;
		end
	end

endmodule

// file: panel_timing_config_regs_sva.sv
`timescale 1ns/1ps
module panel_cfg_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic global_reset_n,
	input wire logic rd_en,
	input wire logic vsync_valid,
	input wire logic port_count_pin,
	input wire logic vstart_req,
	input wire logic rdata_valid,
	input wire panel_cfg_pkg::settings_type active,
	input wire logic two_port_mode,
	input wire logic first_start_output,
	input wire logic second_start_output,
	input wire logic scan_direction_output,
	input wire logic channels_disabled,
	input wire logic [10:0] first_oe_ui,
	input wire logic first_oe_supported
);
	// ****************************************
	// derived outputs lag active by one edge
	// ****************************************
	logic up;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			up <= 1'b0;
		else
			up <= 1'b1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence read_taken; rd_en; endsequence
	sequence read_answer; rdata_valid; endsequence
	chk_read_answer: assert property (read_taken |=> read_answer)
		else $error("read not answered");
	chk_start_route: assert property (vstart_req |=>
		second_start_output == $past(active.vertical_direction) &&
		first_start_output == !$past(active.vertical_direction))
		else $error("start pulse on wrong output");
	chk_scan_dir: assert property (up |->
		scan_direction_output == !$past(active.vertical_direction))
		else $error("scan direction wrong");
	chk_two_port: assert property (up |-> two_port_mode ==
		($past(port_count_pin) ^ $past(active.port_count_select)))
		else $error("port mode wrong");
	chk_channels_off: assert property (up |-> channels_disabled ==
		($past(active.resolution_select) == panel_cfg_pkg::res_1080x1920))
		else $error("channel disable wrong");
	chk_oe_units: assert property (up |->
		first_oe_ui == 11'($past(active.first_oe_width)) *
		11'(panel_cfg_pkg::ui_per_oe_step))
		else $error("oe width wrong");
	chk_oe_support: assert property (up |-> first_oe_supported ==
		($past(active.first_oe_width) >= panel_cfg_pkg::oe_width_min))
		else $error("oe support flag wrong");
	chk_apply_vsync: assert property (!vsync_valid && global_reset_n
		##1 global_reset_n |-> $stable(active))
		else $error("settings applied without vsync");
endmodule
bind panel_timing_config_regs panel_cfg_checker i_chk (.*);

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic global_reset_n = 1'b1;
	logic vsync_valid = 1'b0;
	logic port_count_pin = 1'b1;
	logic vstart_req = 1'b0;
	logic [1:0] driver_location = 2'h0;
	logic wr_en, rd_en, high_speed_write, rdata_valid, two_port_mode, v;
	logic first_start_output, second_start_output, scan_direction_output;
	logic channels_disabled, first_oe_supported;
	logic [7:0] addr, wdata, rdata, d;
	logic [10:0] first_oe_ui;
	panel_cfg_pkg::settings_type active, exp_act;
	panel_cfg_pkg::term_code_type term_select;
	int m[256], act[256], mismatches = 0, compares = 0, cycles = 0, seed = 1964;
	int regs[8] = '{'h91, 'h92, 'h93, 'h97, 'had, 'hae, 'h90, 'h55};
	panel_timing_config_regs i_panel_timing_config_regs (.*);
	host_model i_host_model (.*);
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	// ****************************************
	// reference model and shared checks
	// ****************************************
	function automatic int lfsr(int x);
		return ((x << 1) | (x[15] ^ x[13] ^ x[12] ^ x[10])) & 32'h0000ffff;
	endfunction
	function automatic int wm(int a);
		return (a == 'h90 || a == 'h91) ? 3 : a == 'h92 ? 1 :
			a == 'h93 ? 'hf3 :
			(a == 'h97 || a == 'had) ? 'hff : a == 'hae ? 'h7f : 0;
	endfunction
	function automatic int fx(int a);
		return a == 'h90 ? 'hfc : a == 'h91 ? 4 : a == 'h92 ? 'hce :
			a == 'h93 ? 'h0c : 0;
	endfunction
	task automatic load_rst();
		m = '{default: 0};
		m['h90] = 'hff;
		m['h91] = 'h07;
		m['h92] = 'hcf;
		m['h93] = 'hff;
		m['had] = 'h90;
		m['hae] = 'h54;
		act = m;
	endtask
	task automatic w(int a, int dv, bit hs);
		i_host_model.wr(a[7:0], dv[7:0], hs);
		if (!(hs && a == 'h97)) m[a] = (dv & wm(a)) | fx(a);
	endtask
	task automatic read_all();
		foreach (regs[i]) begin
			i_host_model.rd(regs[i][7:0], d, v);
			`CHK("rdata_valid", 1'b1, v)
			`CHK("rdata", m[regs[i]][7:0], d)
		end
	endtask
	// vs=0 shows settings stay pending until a vsync
	task automatic step(bit vs);
		seed = lfsr(seed);
		@(posedge clk_sys);
		vsync_valid <= vs;
		port_count_pin <= seed[3];
		driver_location <= seed[5:4];
		if (vs) act = m;
		@(posedge clk_sys);
		vsync_valid <= 1'b0;
		@(posedge clk_sys);
		#1;
		exp_act = {act['h90][0], act['h90][1], act['h91][1:0],
			act['h92][0], act['h93][7:4], act['h93][1:0], act['h97][7:0],
			act['had][7:0], act['hae][6:0]};
		`CHK("active", exp_act, active)
		`CHK("two_port", seed[3] ^ act['h93][7], two_port_mode)
		`CHK("chan_off", act['h93][1:0] == 1, channels_disabled)
		`CHK("term", 2'(act['h97] >> (2 * seed[5:4])), term_select)
		`CHK("oe_ui", 11'(act['had][6:0] * 12), first_oe_ui)
		`CHK("oe_ok", act['had][6:0] >= 2, first_oe_supported)
		`CHK("scan_dir", !act['h90][1], scan_direction_output)
		@(posedge clk_sys);
		vstart_req <= 1'b1;
		@(posedge clk_sys);
		vstart_req <= 1'b0;
		#1;
		`CHK("start2", act['h90][1], second_start_output)
		`CHK("start1", !act['h90][1], first_start_output)
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		load_rst();
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		read_all();
		step(0);
		for (int i = 0; i < 12; i++) begin
			foreach (regs[j]) begin
				seed = lfsr(seed);
				if (regs[j] == 'h93) seed[1:0] = i[1:0];
				if (regs[j] == 'h90) seed[1] = i[0];
				if (regs[j] == 'had && i < 4) seed[6:0] = i < 3 ? i : 'h7f;
				w(regs[j], seed[7:0], seed[9]);
			end
			read_all();
			step(0);
			step(1);
		end
		@(posedge clk_sys);
		global_reset_n <= 1'b0;
		@(posedge clk_sys);
		global_reset_n <= 1'b1;
		load_rst();
		step(0);
		read_all();
		end_of_test();
	end
endmodule
